/* File: common/uifl_pkg.sv */
// Constants and types shared by the USB interrupt flag and enable logic
package uifl_pkg;

   // ---------------------------------------------------------------
   // Bus and register geometry
   // ---------------------------------------------------------------
   localparam int ADDR_W   = 12;
   localparam int DATA_W   = 32;
   localparam int IDX_W    = 10;
   localparam int REG_W    = 8;
   localparam int EP_NUM   = 5;
   localparam int EP_SEL_W = 3;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_FIFO_PAIRING = 10'h0e3;
   localparam logic [IDX_W-1:0] IDX_BUS_EV_EN    = 10'h0e4;
   localparam logic [IDX_W-1:0] IDX_IN_EMPTY_EN  = 10'h0e5;
   localparam logic [IDX_W-1:0] IDX_OUT_FULL_EN  = 10'h0e6;
   localparam logic [IDX_W-1:0] IDX_NAK_IRQ_EN   = 10'h0e7;
   localparam logic [IDX_W-1:0] IDX_EV_SUMMARY   = 10'h0e8;
   localparam logic [IDX_W-1:0] IDX_IN_EMPTY     = 10'h0e9;
   localparam logic [IDX_W-1:0] IDX_OUT_FULL     = 10'h0ea;
   localparam logic [IDX_W-1:0] IDX_NAK_FLAG     = 10'h0eb;

   localparam logic [REG_W-1:0] REG_RESET = 8'h00;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int SUM_BUS_EV_BIT   = 7;
   localparam int SUM_IN_EMPTY_BIT = 6;
   localparam int SUM_OUT_FULL_BIT = 5;
   localparam int SUM_NAK_BIT      = 4;
   localparam int BUS_EV_W         = 4;
   localparam int BUS_RESET_BIT    = 3;
   localparam int BUS_IDLE_BIT     = 2;
   localparam int EOP_BIT          = 1;
   localparam int BUS_WAKE_BIT     = 0;

   localparam int PAIR_W           = 4;
   localparam int PAIR_EP1_IN_BIT  = 0;
   localparam int PAIR_EP3_IN_BIT  = 1;
   localparam int PAIR_EP1_OUT_BIT = 2;
   localparam int PAIR_EP3_OUT_BIT = 3;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ      = 100;
   localparam int IDLE_TIME_US = 3000;
   localparam int IDLE_CYCLES  = IDLE_TIME_US * CLK_MHZ;

   // ---------------------------------------------------------------
   // Event strobes from the serial interface engine
   // ---------------------------------------------------------------
   typedef struct packed {
      logic                busReset;
      logic                endOfPacket;
      logic                inToken;
      logic [EP_SEL_W-1:0] inTokenEp;
   } uifl_sie_ev_t;

endpackage

/* File: hdl/uifl_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module uifl_sync (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic pinIn,
   output logic      levelOut
);

   logic stage1_reg;
   logic stage2_reg;
   logic stage3_reg;

   // Only stages two and three are compared; stage one may be metastable
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         stage1_reg <= 1'b0;
         stage2_reg <= 1'b0;
         stage3_reg <= 1'b0;
         levelOut   <= 1'b0;
      end else begin
         stage1_reg <= pinIn;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
         if (stage2_reg == stage3_reg) begin
            levelOut <= stage3_reg;
         end
      end
   end

endmodule

/* File: hdl/uifl_top.sv */
// USB interrupt flag and enable logic with APB register slave
//
// Function
// RULE_01: NAK an IN token when FIFO not ready
// RULE_02: NAK enable register, bits 4..0 per endpoint
// RULE_03: Summary bit 7 ORs the four bus flags
// RULE_04: Summary bit 6 ORs IN empty flags
// RULE_05: Summary bit 5 ORs OUT full flags
// RULE_06: Summary bit 4 ORs NAK flags
// RULE_07: Bus reset sets flag, resets nothing else
// RULE_08: Software restarts engine and reinitialises after reset
// RULE_09: 3 ms idle sets suspend, stops engine clock
// RULE_10: Clearing suspend flag restarts engine clock
// RULE_11: Valid end of packet sets its flag
// RULE_12: Activity during suspend sets wake flag
// RULE_13: Software clears suspend flag on wake
// RULE_14: IN flag sets on FIFO full to empty
// RULE_15: OUT flag sets on FIFO empty to full
// RULE_16: Flags sticky; writing zero clears that bit
// RULE_17: Paired FIFOs raise only odd endpoint flags
// RULE_18: Bus event enable register, four enables
// RULE_19: All sources merge onto one interrupt line
// RULE_20: Pairing register couples endpoints 1-2, 3-4
// RULE_21: NAK flag sets per endpoint on NAK
// RULE_22: Interrupt high while enabled flag is set
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module uifl_top
   import uifl_pkg::*;
#(
   parameter int IDLE_CYCLES_P = IDLE_CYCLES
) (
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [DATA_W-1:0] pwdata,
   output logic      [DATA_W-1:0] prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire uifl_sie_ev_t      sieEv,
   input  wire logic              busActivityPin,
   input  wire logic [EP_NUM-1:0] inFifoEmpty,
   input  wire logic [EP_NUM-1:0] inFifoReady,
   input  wire logic [EP_NUM-1:0] outFifoFull,
   output logic                   nakStb,
   output logic                   sieClkEn,
   output logic      [PAIR_W-1:0] fifoPairing,
   output logic                   usbIrq
);

   localparam int IDLE_W = $clog2(IDLE_CYCLES_P + 1);
   localparam logic [IDLE_W-1:0] IDLE_LIMIT = IDLE_W'(IDLE_CYCLES_P);
   localparam logic [IDLE_W-1:0] IDLE_LAST  = IDLE_W'(IDLE_CYCLES_P - 1);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [BUS_EV_W-1:0] busEvFlag_reg;
   logic [BUS_EV_W-1:0] busEvFlag_next;
   logic [EP_NUM-1:0]   inEmptyFlag_reg;
   logic [EP_NUM-1:0]   inEmptyFlag_next;
   logic [EP_NUM-1:0]   outFullFlag_reg;
   logic [EP_NUM-1:0]   outFullFlag_next;
   logic [EP_NUM-1:0]   nakFlag_reg;
   logic [EP_NUM-1:0]   nakFlag_next;
   logic [BUS_EV_W-1:0] busEvEnable_reg;
   logic [EP_NUM-1:0]   inEmptyEnable_reg;
   logic [EP_NUM-1:0]   outFullEnable_reg;
   logic [EP_NUM-1:0]   nakIrqEnable_reg;
   logic [PAIR_W-1:0]   fifoPairing_reg;
   logic [EP_NUM-1:0]   inEmptyPrev_reg;
   logic [EP_NUM-1:0]   outFullPrev_reg;
   logic [IDLE_W-1:0]   idleCnt_reg;
   logic [IDLE_W-1:0]   idleCnt_next;

   // ---------------------------------------------------------------
   // Pin synchroniser for bus activity
   // ---------------------------------------------------------------
   logic busActive;

   uifl_sync u_activity_sync (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .pinIn    (busActivityPin),
      .levelOut (busActive)
   );

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   wire             apbAccess = psel & penable;
   wire             apbFirst  = apbAccess & ~pready;
   wire             wrEn      = apbAccess & pready & pwrite;
   wire [IDX_W-1:0] regIdx    = paddr[ADDR_W-1:2];
   wire             aligned   = (paddr[1:0] == 2'h0);
   wire [REG_W-1:0] wData     = pwdata[REG_W-1:0];

   wire hitPair   = aligned & (regIdx == IDX_FIFO_PAIRING);
   wire hitBusEn  = aligned & (regIdx == IDX_BUS_EV_EN);
   wire hitInEn   = aligned & (regIdx == IDX_IN_EMPTY_EN);
   wire hitOutEn  = aligned & (regIdx == IDX_OUT_FULL_EN);
   wire hitNakEn  = aligned & (regIdx == IDX_NAK_IRQ_EN);
   wire hitSum    = aligned & (regIdx == IDX_EV_SUMMARY);
   wire hitInFl   = aligned & (regIdx == IDX_IN_EMPTY);
   wire hitOutFl  = aligned & (regIdx == IDX_OUT_FULL);
   wire hitNakFl  = aligned & (regIdx == IDX_NAK_FLAG);
   wire hitAny    = hitPair | hitBusEn | hitInEn | hitOutEn | hitNakEn
                  | hitSum | hitInFl | hitOutFl | hitNakFl;

   // Clear masks: a bit written as zero is cleared, a one leaves it
   wire [REG_W-1:0] keepSum   = ~({REG_W{wrEn & hitSum}} & ~wData);
   wire [REG_W-1:0] keepInFl  = ~({REG_W{wrEn & hitInFl}} & ~wData);
   wire [REG_W-1:0] keepOutFl = ~({REG_W{wrEn & hitOutFl}} & ~wData);
   wire [REG_W-1:0] keepNakFl = ~({REG_W{wrEn & hitNakFl}} & ~wData);

   // ---------------------------------------------------------------
   // Summary bits, derived and never stored
   // ---------------------------------------------------------------
   wire busEvSummary  = |busEvFlag_reg;                 // [RULE_03]
   wire inEmptySum    = |inEmptyFlag_reg;               // [RULE_04]
   wire outFullSum    = |outFullFlag_reg;               // [RULE_05]
   wire nakSummary    = |nakFlag_reg;                   // [RULE_06]
   wire [REG_W-1:0] summaryRead = {busEvSummary, inEmptySum, outFullSum,
                                   nakSummary, busEvFlag_reg};

   // ---------------------------------------------------------------
   // Per-endpoint event detection
   // ---------------------------------------------------------------
   logic [EP_NUM-1:0] inActive;
   logic [EP_NUM-1:0] outActive;
   logic [EP_NUM-1:0] inEmptySet;
   logic [EP_NUM-1:0] outFullSet;
   logic [EP_NUM-1:0] nakRaw;
   logic [EP_NUM-1:0] nakSet;

   for (genvar i = 0; i < EP_NUM; i++) begin : g_ep
      // Even partner of a pair stays quiet; the odd one carries both
      if (i == 2) begin : g_p1
         assign inActive[i]  = ~fifoPairing_reg[PAIR_EP1_IN_BIT];  // [RULE_17]
         assign outActive[i] = ~fifoPairing_reg[PAIR_EP1_OUT_BIT]; // [RULE_17]
      end else if (i == 4) begin : g_p3
         assign inActive[i]  = ~fifoPairing_reg[PAIR_EP3_IN_BIT];  // [RULE_17]
         assign outActive[i] = ~fifoPairing_reg[PAIR_EP3_OUT_BIT]; // [RULE_17]
      end else begin : g_np
         assign inActive[i]  = 1'b1;
         assign outActive[i] = 1'b1;
      end
      assign inEmptySet[i] = inFifoEmpty[i] & ~inEmptyPrev_reg[i]
                           & inActive[i];                      // [RULE_14]
      assign outFullSet[i] = outFullFlag_set(i);
      assign nakRaw[i]     = sieEv.inToken & ~inFifoReady[i]
                           & (sieEv.inTokenEp == EP_SEL_W'(i)); // [RULE_01]
      assign nakSet[i]     = nakRaw[i] & inActive[i];          // [RULE_21]
   end

   function automatic logic outFullFlag_set(input int ep);
      outFullFlag_set = outFifoFull[ep] & ~outFullPrev_reg[ep]
                      & outActive[ep];                          // [RULE_15]
   endfunction

   // ---------------------------------------------------------------
   // Bus idle timing
   // ---------------------------------------------------------------
   // Counter saturates, so suspend is raised once per idle stretch;
   // clearing the flag during a still idle bus does not re-raise it
   wire idleHit = ~busActive & (idleCnt_reg == IDLE_LAST);      // [RULE_09]
   assign idleCnt_next = busActive ? '0 :
                         (idleCnt_reg == IDLE_LIMIT) ? idleCnt_reg :
                         idleCnt_reg + IDLE_W'(1);

   wire wakeSet = busActive & busEvFlag_reg[BUS_IDLE_BIT];      // [RULE_12]

   // ---------------------------------------------------------------
   // Flag next state: hardware set wins over a software clear
   // ---------------------------------------------------------------
   wire [BUS_EV_W-1:0] busEvSet;
   assign busEvSet[BUS_RESET_BIT] = sieEv.busReset;             // [RULE_07]
   assign busEvSet[BUS_IDLE_BIT]  = idleHit;                    // [RULE_09]
   assign busEvSet[EOP_BIT]       = sieEv.endOfPacket;          // [RULE_11]
   assign busEvSet[BUS_WAKE_BIT]  = wakeSet;                    // [RULE_12]

   assign busEvFlag_next   = (busEvFlag_reg & keepSum[BUS_EV_W-1:0])
                           | busEvSet;                          // [RULE_16]
   assign inEmptyFlag_next = (inEmptyFlag_reg & keepInFl[EP_NUM-1:0])
                           | inEmptySet;                        // [RULE_16]
   assign outFullFlag_next = (outFullFlag_reg & keepOutFl[EP_NUM-1:0])
                           | outFullSet;                        // [RULE_16]
   assign nakFlag_next     = (nakFlag_reg & keepNakFl[EP_NUM-1:0])
                           | nakSet;                            // [RULE_16]

   // ---------------------------------------------------------------
   // Interrupt merge
   // ---------------------------------------------------------------
   wire irqNext = |(busEvFlag_reg & busEvEnable_reg)
                | |(inEmptyFlag_reg & inEmptyEnable_reg)
                | |(outFullFlag_reg & outFullEnable_reg)
                | |(nakFlag_reg & nakIrqEnable_reg);            // [RULE_22]

   // ---------------------------------------------------------------
   // Read multiplexer
   // ---------------------------------------------------------------
   localparam int PAD_EP  = REG_W - EP_NUM;
   localparam int PAD_BUS = REG_W - BUS_EV_W;
   localparam int PAD_DAT = DATA_W - REG_W;

   wire [REG_W-1:0] readByte =
        hitPair  ? {{PAD_BUS{1'b0}}, fifoPairing_reg}   :
        hitBusEn ? {{PAD_BUS{1'b0}}, busEvEnable_reg}   :
        hitInEn  ? {{PAD_EP{1'b0}},  inEmptyEnable_reg} :
        hitOutEn ? {{PAD_EP{1'b0}},  outFullEnable_reg} :
        hitNakEn ? {{PAD_EP{1'b0}},  nakIrqEnable_reg}  :
        hitSum   ? summaryRead                          :
        hitInFl  ? {{PAD_EP{1'b0}},  inEmptyFlag_reg}   :
        hitOutFl ? {{PAD_EP{1'b0}},  outFullFlag_reg}   :
        hitNakFl ? {{PAD_EP{1'b0}},  nakFlag_reg}       :
        REG_RESET;

   // ---------------------------------------------------------------
   // APB slave: one wait state, reply registered
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= apbFirst;
         pslverr <= apbFirst & ~hitAny;
         if (apbFirst & ~pwrite) begin
            prdata <= {{PAD_DAT{1'b0}}, readByte};
         end
      end
   end

   // ---------------------------------------------------------------
   // Software-written configuration
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         busEvEnable_reg   <= REG_RESET[BUS_EV_W-1:0];
         inEmptyEnable_reg <= REG_RESET[EP_NUM-1:0];
         outFullEnable_reg <= REG_RESET[EP_NUM-1:0];
         nakIrqEnable_reg  <= REG_RESET[EP_NUM-1:0];
         fifoPairing_reg   <= REG_RESET[PAIR_W-1:0];
      end else if (wrEn) begin
         if (hitBusEn) begin
            busEvEnable_reg <= wData[BUS_EV_W-1:0];             // [RULE_18]
         end
         if (hitInEn) begin
            inEmptyEnable_reg <= wData[EP_NUM-1:0];
         end
         if (hitOutEn) begin
            outFullEnable_reg <= wData[EP_NUM-1:0];
         end
         if (hitNakEn) begin
            nakIrqEnable_reg <= wData[EP_NUM-1:0];              // [RULE_02]
         end
         if (hitPair) begin
            fifoPairing_reg <= wData[PAIR_W-1:0];               // [RULE_20]
         end
      end
   end

   // ---------------------------------------------------------------
   // Flags and event history
   // ---------------------------------------------------------------
   // Bus reset only touches its flag; engine and CPU state stay intact
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         busEvFlag_reg   <= REG_RESET[BUS_EV_W-1:0];
         inEmptyFlag_reg <= REG_RESET[EP_NUM-1:0];
         outFullFlag_reg <= REG_RESET[EP_NUM-1:0];
         nakFlag_reg     <= REG_RESET[EP_NUM-1:0];
         inEmptyPrev_reg <= {EP_NUM{1'b1}};
         outFullPrev_reg <= {EP_NUM{1'b0}};
         idleCnt_reg     <= '0;
      end else begin
         busEvFlag_reg   <= busEvFlag_next;                     // [RULE_07]
         inEmptyFlag_reg <= inEmptyFlag_next;
         outFullFlag_reg <= outFullFlag_next;
         nakFlag_reg     <= nakFlag_next;
         inEmptyPrev_reg <= inFifoEmpty;
         outFullPrev_reg <= outFifoFull;
         idleCnt_reg     <= idleCnt_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Engine clock follows the suspend flag; software owns the restart
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         nakStb      <= 1'b0;
         sieClkEn    <= 1'b1;
         fifoPairing <= REG_RESET[PAIR_W-1:0];
         usbIrq      <= 1'b0;
      end else begin
         nakStb      <= |nakRaw;                                // [RULE_01]
         sieClkEn    <= ~busEvFlag_next[BUS_IDLE_BIT];    // [RULE_09] [RULE_10]
         fifoPairing <= fifoPairing_reg;
         usbIrq      <= irqNext;                                // [RULE_19]
      end
   end

endmodule

/* File: tb/uifl_top_properties.sv */
// Port-level assertions for the USB flag and enable logic
`timescale 1ns/1ps
module uifl_top_properties
   import uifl_pkg::*;
#(
   parameter int IDLE_CYCLES_P = IDLE_CYCLES
) (
   input wire logic              ref_clk,
   input wire logic              rst,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [DATA_W-1:0] prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire uifl_sie_ev_t      sieEv,
   input wire logic              busActivityPin,
   input wire logic [EP_NUM-1:0] inFifoEmpty,
   input wire logic [EP_NUM-1:0] inFifoReady,
   input wire logic [EP_NUM-1:0] outFifoFull,
   input wire logic              nakStb,
   input wire logic              sieClkEn,
   input wire logic [PAIR_W-1:0] fifoPairing,
   input wire logic              usbIrq
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic [IDX_W-1:0] idx;
   logic             rdDone;
   logic             wrDone;
   logic             notReady;
   assign idx = paddr[11:2];
   assign rdDone = psel && penable && pready && !pwrite;
   assign wrDone = psel && penable && pready && pwrite;
   assign notReady = sieEv.inToken && sieEv.inTokenEp < 3'h5
                     && !inFifoReady[sieEv.inTokenEp];
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   sequence s_access; psel && penable && !pready; endsequence
   sequence s_answer; psel && penable && pready; endsequence
   property p_one_wait; s_access |=> s_answer; endproperty
   property p_err_pulse; pslverr |-> pready; endproperty
   property p_unmapped;
      psel && penable && pready && (idx < 10'h0e3 || idx > 10'h0eb)
      |-> pslverr;
   endproperty
   property p_nak; notReady |=> nakStb; endproperty
   property p_nak_cause; nakStb |-> $past(sieEv.inToken); endproperty
   property p_nak_rsvd;
      rdDone && idx == IDX_NAK_IRQ_EN |-> prdata[31:5] == 27'h0;
   endproperty
   property p_glf;
      rdDone && idx == IDX_EV_SUMMARY |-> prdata[7] == |prdata[3:0];
   endproperty
   property p_clk_on;
      wrDone && idx == IDX_EV_SUMMARY && !pwdata[BUS_IDLE_BIT]
      |=> sieClkEn;
   endproperty
   property p_clk_off;
      $fell(sieClkEn) |-> !$past(busActivityPin, 8);
   endproperty
   property p_pair;
      wrDone && idx == IDX_FIFO_PAIRING
      |=> ##1 fifoPairing == $past(pwdata[3:0], 2);
   endproperty
   a_one_wait: assert property (p_one_wait)
      else $error("pready not after one wait state");
   a_err_pulse: assert property (p_err_pulse)
      else $error("pslverr without pready");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped access not refused");
   a_nak: assert property (p_nak)
      else $error("missing nak strobe");
   a_nak_cause: assert property (p_nak_cause)
      else $error("nak strobe without token");
   a_nak_rsvd: assert property (p_nak_rsvd)
      else $error("nak enable reserved bits set");
   a_glf: assert property (p_glf)
      else $error("bus summary bit wrong");
   a_clk_on: assert property (p_clk_on)
      else $error("engine clock not restarted");
   a_clk_off: assert property (p_clk_off)
      else $error("engine clock stopped during activity");
   a_pair: assert property (p_pair)
      else $error("pairing output wrong");
endmodule

bind uifl_top uifl_top_properties #(.IDLE_CYCLES_P(IDLE_CYCLES_P)) chk (
   .ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .sieEv, .busActivityPin, .inFifoEmpty,
   .inFifoReady, .outFifoFull, .nakStb, .sieClkEn, .fifoPairing, .usbIrq);

/* File: tb/uifl_host_model.sv */
// Behavioural full-speed host: bus events, tokens and idle stretches
`timescale 1ns/1ps
module uifl_host_model
   import uifl_pkg::*;
(
   input wire logic     ref_clk,
   output uifl_sie_ev_t sieEv,
   output logic         busActivityPin
);
   initial begin
      sieEv = '0;
      busActivityPin = 1'b1;
   end
   // One-cycle event, as the engine reports it
   task automatic send(input logic r, input logic e, input logic t,
                       input logic [EP_SEL_W-1:0] ep);
      @(posedge ref_clk);
      sieEv.busReset <= r;
      sieEv.endOfPacket <= e;
      sieEv.inToken <= t;
      sieEv.inTokenEp <= ep;
      @(posedge ref_clk);
      sieEv <= '0;
   endtask
   task automatic set_active(input logic a);
      @(posedge ref_clk);
      busActivityPin <= a;
   endtask
endmodule

/* File: tb/uifl_top_tb.sv */
// Self-checking bench for the USB flag and enable logic
`timescale 1ns/1ps
module uifl_top_tb import uifl_pkg::*;
;
   localparam int IDLE_P = 20;
   logic              ref_clk = 1'b0;
   logic              rst = 1'b1;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [DATA_W-1:0] prdata;
   logic              pready;
   logic              pslverr;
   uifl_sie_ev_t      sieEv;
   logic              busActivityPin;
   logic [EP_NUM-1:0] inFifoEmpty = 5'h1f;
   logic [EP_NUM-1:0] inFifoReady = 5'h00;
   logic [EP_NUM-1:0] outFifoFull = 5'h00;
   logic              nakStb;
   logic              sieClkEn;
   logic [PAIR_W-1:0] fifoPairing;
   logic              usbIrq;
   logic [7:0]        rd;
   logic              err;
   int                miscompares = 0;
   int                checks = 0;
   int                cycles = 0;

   uifl_top #(.IDLE_CYCLES_P(IDLE_P)) uut (
      .ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .sieEv, .busActivityPin, .inFifoEmpty,
      .inFifoReady, .outFifoFull, .nakStb, .sieClkEn, .fifoPairing,
      .usbIrq);
   uifl_host_model host (.ref_clk, .sieEv, .busActivityPin);

   always #5 ref_clk = ~ref_clk;
   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles > 6000) begin
         miscompares++;
         complete_run();
      end
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic complete_run();
      $display("Checks %0d mismatches %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [IDX_W-1:0] idx,
                      input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n == 16) miscompares++;
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
   endtask
   task automatic rdchk(input logic [IDX_W-1:0] idx,
                        input logic [7:0] exp, input string nm);
      apb(1'b0, idx, 8'h00);
      check(nm, rd, exp);
   endtask
   // Flag round over all endpoints with one pairing setting
   task automatic ep_round(input logic [3:0] pair, input logic [4:0] exp);
      wr(IDX_FIFO_PAIRING, {4'h0, pair});
      repeat (2) @(posedge ref_clk);
      check("pairing", fifoPairing, pair);
      inFifoEmpty <= 5'h00;
      outFifoFull <= 5'h1f;
      @(posedge ref_clk);
      inFifoEmpty <= 5'h1f;
      for (int e = 0; e < EP_NUM; e++) host.send(0, 0, 1, 3'(e));
      rdchk(IDX_IN_EMPTY, {3'h0, exp}, "in");
      rdchk(IDX_OUT_FULL, {3'h0, exp}, "out");
      rdchk(IDX_NAK_FLAG, {3'h0, exp}, "nak");
      rdchk(IDX_EV_SUMMARY, 8'h70, "ep sum");
      check("nak irq", usbIrq, 1'b1);
      wr(IDX_IN_EMPTY, 8'hfe);
      rdchk(IDX_IN_EMPTY, {3'h0, exp & 5'h1e}, "in bit0");
      wr(IDX_IN_EMPTY, 8'h00);
      wr(IDX_OUT_FULL, 8'h00);
      wr(IDX_NAK_FLAG, 8'h00);
      rdchk(IDX_EV_SUMMARY, 8'h00, "ep cleared");
      check("irq off", usbIrq, 1'b0);
      outFifoFull <= 5'h00;
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      int n;
      n = 0;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      check("clk en reset", sieClkEn, 1'b1);
      for (int i = 'h0e3; i <= 'h0eb; i++) rdchk(10'(i), 8'h00, "reset");
      wr(IDX_NAK_IRQ_EN, 8'hff);
      rdchk(IDX_NAK_IRQ_EN, 8'h1f, "nak en");
      wr(IDX_BUS_EV_EN, 8'hff);
      rdchk(IDX_BUS_EV_EN, 8'h0f, "bus en");
      wr(IDX_EV_SUMMARY, 8'hf0);
      rdchk(IDX_EV_SUMMARY, 8'h00, "summary ro");
      apb(1'b0, 10'h0e2, 8'h00);
      check("unmapped err", err, 1'b1);
      check("unmapped rd", rd, 8'h00);
      apb(1'b1, 10'h0ec, 8'hff);
      check("unmapped wr", err, 1'b1);
      $display("Test registers done");
      host.send(1'b1, 1'b0, 1'b0, 3'h0);
      host.send(1'b0, 1'b1, 1'b0, 3'h0);
      rdchk(IDX_EV_SUMMARY, 8'h8a, "bus ev");
      check("irq", usbIrq, 1'b1);
      check("clk kept", sieClkEn, 1'b1);
      rdchk(IDX_BUS_EV_EN, 8'h0f, "en kept");
      wr(IDX_EV_SUMMARY, 8'hf7);
      rdchk(IDX_EV_SUMMARY, 8'h82, "rst cleared");
      wr(IDX_BUS_EV_EN, 8'h0d);
      repeat (2) @(posedge ref_clk);
      check("irq masked", usbIrq, 1'b0);
      wr(IDX_BUS_EV_EN, 8'h0f);
      wr(IDX_EV_SUMMARY, 8'h00);
      $display("Test bus events done");
      host.set_active(1'b0);
      repeat (10) @(posedge ref_clk);
      check("clk early", sieClkEn, 1'b1);
      while (sieClkEn !== 1'b0 && n < 100) begin
         @(posedge ref_clk);
         n++;
      end
      check("idle time", n + 10 >= IDLE_P && n + 10 <= IDLE_P + 6, 1'b1);
      rdchk(IDX_EV_SUMMARY, 8'h84, "suspend");
      check("irq idle", usbIrq, 1'b1);
      host.set_active(1'b1);
      repeat (8) @(posedge ref_clk);
      rdchk(IDX_EV_SUMMARY, 8'h85, "wake");
      check("clk off", sieClkEn, 1'b0);
      wr(IDX_EV_SUMMARY, 8'hfb);
      @(posedge ref_clk);
      check("clk on", sieClkEn, 1'b1);
      rdchk(IDX_EV_SUMMARY, 8'h81, "wake kept");
      wr(IDX_EV_SUMMARY, 8'h00);
      $display("Test suspend done");
      inFifoReady <= 5'h01;
      host.send(1'b0, 1'b0, 1'b1, 3'h0);
      rdchk(IDX_NAK_FLAG, 8'h00, "ready no nak");
      inFifoReady <= 5'h00;
      ep_round(4'h0, 5'h1f);
      ep_round(4'h5, 5'h1b);
      ep_round(4'ha, 5'h0f);
      ep_round(4'hf, 5'h0b);
      $display("Test endpoints done");
      complete_run();
   end
endmodule
